/* File: rtl/tug3_mux_regs.vh */
// constants of the tug-3 multiplex overhead source: register map, fields, frame layout
`ifndef TUG3_MUX_REGS_VH
`define TUG3_MUX_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_ACT0 8'h04
`define OFF_ACT1 8'h08
`define OFF_ACT2 8'h0c
`define OFF_STATUS 8'h10
`define OFF_UNDERRUN 8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTRL_ACTIVE_BIT 0
`define CTRL_RESET 1'b0
`define ACT0_WIDTH 21
`define ACT1_WIDTH 32
`define ACT2_WIDTH 25
`define ACT_RESET 32'h0000_0000
`define STATUS_CONFLICT_BIT 4
`define UNDERRUN_RESET 16'h0000

// ----------------------------------------------------------------
// frame layout (bytes per row, one byte per clock)
// ----------------------------------------------------------------
`define ROW_LEN 5'h1b
`define ROW_COUNT 4'h9
`define R0_COL0 5'h01
`define TUG_COL0 5'h03
`define MA_ROW 4'h0
`define TUG2_AB_LAST 3'h6
`define TUG2_C_COUNT 3'h5
`define GROUP_STUFF_W 3'h7
`define TU12_PER_TUG2 2'h3
`define MFI_LAST 2'h3
`define SIGNAL_LABEL 3'b100
`define STUFF_BYTE 8'h00
`define FILL_BYTE 8'hff
`define POH_OTHER 8'h00
`define FIFO_DEPTH 8

`endif

/* File: rtl/tug3_fifo.v */
// fifo of flip-flops between the tributary feed and the multiplexer
`timescale 1ns/1ps
module tug3_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready,
   output wire [AW:0] level
);
   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // entries
   reg [AW:0] wr_ptr; // extra bit tells full from empty
   reg [AW:0] rd_ptr;
   wire do_wr;
   wire do_rd;

   assign level = wr_ptr - rd_ptr;
   assign in_ready = (level != DEPTH[AW:0]);
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   // pointers move only on accepted handshakes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // data storage has no reset; it is read only once valid
   always @(posedge pclk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule // tug3_fifo

/* File: rtl/tributary_adapter.v */
// one tributary slot owner, named by its group.tug2.tu12 index
`timescale 1ns/1ps
module tributary_adapter #(
   parameter [1:0] K = 2'h0, // group: 0 A, 1 B, 2 C
   parameter [3:0] L = 4'h0, // tug-2 number, 0 for a tu-3
   parameter [1:0] M = 2'h0 // tu-12 number, 0 when absent
) (
   input wire pclk,
   input wire presetn,
   input wire frame_start_in,
   input wire activate,
   input wire slot_valid,
   input wire [1:0] slot_k,
   input wire [3:0] slot_l,
   input wire [1:0] slot_m,
   output reg active,
   output wire claim
);
   // activation is taken at a frame boundary so a slot never changes owner mid-frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
      end else if (frame_start_in) begin
         active <= activate;
      end
   end

   // the index alone decides which byte positions this adapter owns
   assign claim = active && slot_valid && (slot_k == K) &&
                  ((L == 4'h0) || (slot_l == L)) && ((M == 2'h0) || (slot_m == M));
endmodule // tributary_adapter

/* File: rtl/group_to_path_adapter.v */
// tug-3 multiplex source: slot owners, pass-through stage, overhead and stuff insertion
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "tug3_mux_regs.vh"
module group_to_path_adapter #(
   parameter FIFO_WIDTH = 8,
   parameter FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire pclk,
   input wire presetn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire frame_start_in,
   input wire multiframe_start,
   input wire [7:0] trib_data,
   input wire trib_valid,
   output wire trib_ready,
   output reg [7:0] path_payload_data,
   output reg path_frame_start,
   output reg path_clock_out,
   output reg path_drive_enable,
   output wire group_a_single_tu_flag,
   output wire group_b_single_tu_flag
);
   localparam ADAPTERS = 78; // 2 tu-3, 19 tu-2, 57 tu-12
   localparam [31:0] ACT_ZERO = `ACT_RESET; // activation reset word, sliced to each register's width

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   reg function_active; // ctrl bit 0
   reg [`ACT0_WIDTH-1:0] act0; // tu-3 a,b then 19 tu-2
   reg [`ACT1_WIDTH-1:0] act1; // tu-12 0..31
   reg [`ACT2_WIDTH-1:0] act2; // tu-12 32..56
   reg conflict; // sticky: two owners met on one slot
   reg [15:0] underrun; // tributary bytes missing at their slot
   reg [1:0] mfi; // multiframe indicator of the current frame
   reg [31:0] next_prdata;
   reg mapped; // address decodes to a register
   wire wr_en;
   wire [3:0] fifo_level;

   assign pready = 1'b1; // zero wait states
   assign wr_en = psel && penable && pwrite;
   assign pslverr = psel && penable && !mapped;

   // read mux, evaluated for the address on the bus
   always @* begin
      mapped = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
         `OFF_CTRL: next_prdata = {31'h0000_0000, function_active};
         `OFF_ACT0: next_prdata = {11'h000, act0};
         `OFF_ACT1: next_prdata = act1;
         `OFF_ACT2: next_prdata = {7'h00, act2};
         `OFF_STATUS: next_prdata = {20'h00000, fifo_level, 2'h0, mfi, 1'b0, conflict,
                                     group_b_single_tu_flag, group_a_single_tu_flag};
         `OFF_UNDERRUN: next_prdata = {16'h0000, underrun};
         default: mapped = 1'b0; // unmapped: reads zero, answers with pslverr
      endcase
   end

   // read data is captured in the setup cycle so it stands through the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // writable registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         function_active <= `CTRL_RESET;
         act0 <= ACT_ZERO[`ACT0_WIDTH-1:0];
         act1 <= ACT_ZERO[`ACT1_WIDTH-1:0];
         act2 <= ACT_ZERO[`ACT2_WIDTH-1:0];
      end else if (wr_en) begin
         case (paddr)
            `OFF_CTRL: function_active <= pwdata[`CTRL_ACTIVE_BIT];
            `OFF_ACT0: act0 <= pwdata[`ACT0_WIDTH-1:0];
            `OFF_ACT1: act1 <= pwdata[`ACT1_WIDTH-1:0];
            `OFF_ACT2: act2 <= pwdata[`ACT2_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // frame position counters
   // ----------------------------------------------------------------
   reg [4:0] col; // column of the coming byte
   reg [3:0] row;
   reg [1:0] grp; // tug-3 group of a tug column: 0 A, 1 B, 2 C
   reg [2:0] wcol; // column within the group
   reg [1:0] mrow; // row modulo three picks the tu-12
   wire [4:0] cur_col;
   wire [3:0] cur_row;
   wire [1:0] cur_grp;
   wire [2:0] cur_wcol;
   wire [1:0] cur_mrow;
   wire [1:0] cur_mfi;
   wire row_end;
   wire frame_byte0;

   // a frame start forces the current byte to position zero
   assign cur_col = frame_start_in ? 5'h00 : col;
   assign cur_row = frame_start_in ? 4'h0 : row;
   assign cur_grp = frame_start_in ? 2'h0 : grp;
   assign cur_wcol = frame_start_in ? 3'h0 : wcol;
   assign cur_mrow = frame_start_in ? 2'h0 : mrow;
   assign row_end = (cur_col == `ROW_LEN - 5'h01);
   assign frame_byte0 = (cur_col == 5'h00) && (cur_row == 4'h0);

   // counters free-run between frame starts, one byte per clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col <= 5'h00;
         row <= 4'h0;
         grp <= 2'h0;
         wcol <= 3'h0;
         mrow <= 2'h0;
      end else begin
         col <= row_end ? 5'h00 : cur_col + 5'h01;
         if (row_end) begin
            if (cur_row == `ROW_COUNT - 4'h1) begin
               row <= 4'h0;
               mrow <= 2'h0;
            end else begin
               row <= cur_row + 4'h1;
               mrow <= (cur_mrow == `TU12_PER_TUG2 - 2'h1) ? 2'h0 : cur_mrow + 2'h1;
            end
         end else begin
            row <= cur_row;
            mrow <= cur_mrow;
         end
         // group and group column restart before the first tug column
         if (row_end || cur_col < `TUG_COL0) begin
            grp <= 2'h0;
            wcol <= 3'h0;
         end else if (cur_grp == 2'h2) begin
            grp <= 2'h0;
            wcol <= cur_wcol + 3'h1;
         end else begin
            grp <= cur_grp + 2'h1;
            wcol <= cur_wcol;
         end
      end
   end

   // ----------------------------------------------------------------
   // byte classification
   // ----------------------------------------------------------------
   wire in_poh;
   wire in_r0;
   wire in_tug;
   wire in_c_stuff;
   wire in_a_stuff;
   wire in_b_stuff;
   wire trib_slot;

   assign in_poh = (cur_col < `R0_COL0);
   assign in_r0 = (cur_col < `TUG_COL0) && !in_poh;
   assign in_tug = !in_poh && !in_r0;
   // group C holds only five tug-2s; its spare columns are base stuff
   assign in_c_stuff = in_tug && (cur_grp == 2'h2) && (cur_wcol >= `TUG2_C_COUNT);
   assign in_a_stuff = in_tug && (cur_grp == 2'h0) && (cur_wcol == `GROUP_STUFF_W) && !group_a_single_tu_flag;
   assign in_b_stuff = in_tug && (cur_grp == 2'h1) && (cur_wcol == `GROUP_STUFF_W) && !group_b_single_tu_flag;
   assign trib_slot = in_tug && !in_c_stuff && !in_a_stuff && !in_b_stuff;

   // ----------------------------------------------------------------
   // tributary adapters, one per possible index
   // ----------------------------------------------------------------
   wire [ADAPTERS-1:0] act_vec;
   wire [ADAPTERS-1:0] claims;
   wire [ADAPTERS-1:0] actives;
   wire [3:0] slot_l;

   assign act_vec = {act2, act1, act0};
   assign slot_l = {1'b0, cur_wcol} + 4'h1;

   genvar i;
   generate
      for (i = 0; i < ADAPTERS; i = i + 1) begin : g_trib
         // index 0..1 tu-3, 2..20 tu-2, 21..77 tu-12
         localparam integer TUG2 = (i < 21) ? (i - 2) : ((i - 21) / 3);
         localparam integer KI = (i < 2) ? i : (TUG2 / 7);
         localparam integer LI = (i < 2) ? 0 : (TUG2 % 7 + 1);
         localparam integer MI = (i < 21) ? 0 : ((i - 21) % 3 + 1);
         tributary_adapter #(
            .K(KI[1:0]),
            .L(LI[3:0]),
            .M(MI[1:0])
         ) u_trib (
            .pclk(pclk),
            .presetn(presetn),
            .frame_start_in(frame_start_in),
            .activate(act_vec[i]),
            .slot_valid(trib_slot),
            .slot_k(cur_grp),
            .slot_l(slot_l),
            .slot_m(cur_mrow + 2'h1),
            .active(actives[i]),
            .claim(claims[i])
         );
      end
   endgenerate

   // flags follow the tu-3 adapters of groups A and B exactly
   assign group_a_single_tu_flag = actives[0];
   assign group_b_single_tu_flag = actives[1];

   // count owners of this byte; more than one means a bad activation set
   reg [6:0] owners;
   integer n;
   always @* begin
      owners = 7'h00;
      for (n = 0; n < ADAPTERS; n = n + 1) begin
         owners = owners + {6'h00, claims[n]};
      end
   end

   wire owned; // some adapter owns this slot
   wire multi; // several adapters own it
   assign owned = (owners != 7'h00);
   assign multi = (owners > 7'h01);

   // ----------------------------------------------------------------
   // tributary byte feed
   // ----------------------------------------------------------------
   wire [7:0] fifo_data;
   wire fifo_valid;
   wire take;
   wire starved;

   // bytes leave the fifo only for owned slots of an active function
   assign take = function_active && trib_slot && owned && fifo_valid;
   assign starved = function_active && trib_slot && owned && !fifo_valid;

   tug3_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_data(trib_data),
      .in_valid(trib_valid),
      .in_ready(trib_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(take),
      .level(fifo_level)
   );

   // ----------------------------------------------------------------
   // pass-through stage between adapters and overhead insertion
   // ----------------------------------------------------------------
   wire [7:0] pt_data;
   wire pt_strobe;
   wire pt_fs;
   wire pt_mfs;

   group_passthrough_stage u_pass (
      .in_data(fifo_data),
      .in_strobe(take),
      .in_fs(frame_byte0),
      .in_mfs(multiframe_start),
      .out_data(pt_data),
      .out_strobe(pt_strobe),
      .out_fs(pt_fs),
      .out_mfs(pt_mfs)
   );

   // multiframe indicator steps once per frame, zeroed by multiframe start
   assign cur_mfi = frame_start_in ? (pt_mfs ? 2'h0 : mfi + 2'h1) : mfi;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mfi <= `MFI_LAST;
      end else begin
         mfi <= cur_mfi;
      end
   end

   // ----------------------------------------------------------------
   // overhead and stuff insertion
   // ----------------------------------------------------------------
   reg [7:0] next_byte;

   always @* begin
      if (in_poh) begin
         // only the signal label and multiframe bits are this block's
         next_byte = (cur_row == `MA_ROW) ? {2'b00, `SIGNAL_LABEL, cur_mfi, 1'b0} : `POH_OTHER;
      end else if (in_r0 || in_c_stuff || in_a_stuff || in_b_stuff) begin
         next_byte = `STUFF_BYTE;
      end else if (pt_strobe) begin
         next_byte = pt_data;
      end else begin
         // unowned or starved slot: all ones keeps the payload sane
         next_byte = `FILL_BYTE;
      end
   end

   // payload data holds still; frame start, clock out and drive enable drop while inactive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         path_payload_data <= 8'h00;
         path_frame_start <= 1'b0;
         path_clock_out <= 1'b0;
         path_drive_enable <= 1'b0;
      end else if (function_active) begin
         path_payload_data <= next_byte;
         path_frame_start <= pt_fs;
         path_clock_out <= 1'b1;
         path_drive_enable <= 1'b1;
      end else begin
         path_frame_start <= 1'b0;
         path_clock_out <= 1'b0;
         path_drive_enable <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // status: conflicts and underruns, the event wins over a clear
   // ----------------------------------------------------------------
   wire clr_conflict;
   wire clr_underrun;
   assign clr_conflict = wr_en && (paddr == `OFF_STATUS) && pwdata[`STATUS_CONFLICT_BIT];
   assign clr_underrun = wr_en && (paddr == `OFF_UNDERRUN);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conflict <= 1'b0;
         underrun <= `UNDERRUN_RESET;
      end else begin
         if (multi) begin
            conflict <= 1'b1;
         end else if (clr_conflict) begin
            conflict <= 1'b0;
         end
         if (clr_underrun) begin
            underrun <= starved ? 16'h0001 : 16'h0000;
         end else if (starved && underrun != 16'hffff) begin
            underrun <= underrun + 16'h0001; // saturates rather than wraps
         end
      end
   end
endmodule // group_to_path_adapter

// forwards data, strobe, frame and multiframe start untouched
module group_passthrough_stage (
   input wire [7:0] in_data,
   input wire in_strobe,
   input wire in_fs,
   input wire in_mfs,
   output wire [7:0] out_data,
   output wire out_strobe,
   output wire out_fs,
   output wire out_mfs
);
   // no processing, no monitoring and no added delay
   assign {out_data, out_strobe, out_fs, out_mfs} = {in_data, in_strobe, in_fs, in_mfs};
endmodule // group_passthrough_stage

/* File: verif/tug3_mux_checker_assertions.sv */
// port assertions for the tug-3 multiplex overhead source
`timescale 1ns/1ps
module tug3_mux_checker (
   input wire pclk,
   input wire presetn,
   input wire frame_start_in,
   input wire multiframe_start,
   input wire [7:0] path_payload_data,
   input wire path_frame_start,
   input wire path_clock_out,
   input wire path_drive_enable,
   input wire group_a_single_tu_flag,
   input wire group_b_single_tu_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // helper: columns and indicator rebuilt from the inputs alone
   // ----------------------------------------------------------------
   reg [4:0] col; // column of the next input byte
   reg [4:0] oc; // column of the byte now on the outputs
   reg sync; // a frame start has fixed the columns
   reg [1:0] mfi; // indicator the current frame's overhead byte carries
   wire [4:0] cc = frame_start_in ? 5'h00 : col;
   wire stuff = (oc == 5'h01) || (oc == 5'h02) || (oc == 5'h14) || (oc == 5'h17) || (oc == 5'h1a);
   // kept apart from the design so a stuck design counter cannot hide
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col <= 5'h00;
         oc <= 5'h00;
         sync <= 1'b0;
         mfi <= 2'h3;
      end else begin
         col <= (cc == 5'h1a) ? 5'h00 : cc + 5'h01;
         oc <= cc;
         if (frame_start_in) begin
            sync <= 1'b1;
            mfi <= multiframe_start ? 2'h0 : mfi + 2'h1;
         end
      end
   end
   a_fs_forward: assert property (frame_start_in ##1 path_drive_enable |-> path_frame_start && path_clock_out)
      else $error("frame start not forwarded");
   a_label_code: assert property (path_frame_start |-> (path_payload_data & 8'hf9) == 8'h20)
      else $error("signal label code wrong");
   a_mfi_align: assert property (frame_start_in && multiframe_start ##1 path_drive_enable |-> path_payload_data[2:1] == 2'h0)
      else $error("indicator not aligned to multiframe start");
   a_mfi_count: assert property (path_frame_start |-> path_payload_data[2:1] == mfi)
      else $error("indicator out of sequence");
   a_base_stuff: assert property (path_clock_out && sync && stuff |-> path_payload_data == 8'h00)
      else $error("base stuff byte missing");
   a_group_a_stuff: assert property (path_clock_out && sync && oc == 5'h18
      |-> (path_payload_data == 8'h00) == !group_a_single_tu_flag) else $error("group a stuff wrong");
   a_group_b_stuff: assert property (path_clock_out && sync && oc == 5'h19
      |-> (path_payload_data == 8'h00) == !group_b_single_tu_flag) else $error("group b stuff wrong");
   a_quiet_off: assert property (!path_drive_enable |-> !path_clock_out && !path_frame_start)
      else $error("output strobes while inactive");
   a_hold_off: assert property (!path_drive_enable && !$past(path_drive_enable) |-> $stable(path_payload_data))
      else $error("data moved while inactive");
   a_flag_moment: assert property ($changed(group_a_single_tu_flag) || $changed(group_b_single_tu_flag)
      |-> $past(frame_start_in)) else $error("flag changed away from frame start");
endmodule // tug3_mux_checker
bind group_to_path_adapter tug3_mux_checker u_tug3_mux_checker (.pclk, .presetn, .frame_start_in, .multiframe_start,
   .path_payload_data, .path_frame_start, .path_clock_out, .path_drive_enable, .group_a_single_tu_flag,
   .group_b_single_tu_flag);

/* File: verif/trib_source.sv */
// tributary byte source standing in for the lower order adapters
`timescale 1ns/1ps
module trib_source (
   input wire pclk,
   input wire presetn,
   input wire enable,
   input wire trib_ready,
   output reg [7:0] trib_data,
   output reg trib_valid
);
   // ----------------------------------------------------------------
   // byte feed
   // ----------------------------------------------------------------
   // bytes run 01..fe so neither a 00 stuff byte nor an ff gap passes for data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trib_data <= 8'h01;
         trib_valid <= 1'b0;
      end else if (trib_valid && trib_ready) begin
         trib_valid <= enable;
         trib_data <= (trib_data == 8'hfe) ? 8'h01 : trib_data + 8'h01;
      end else if (!trib_valid) begin
         // an offered byte stays until the fifo takes it
         trib_valid <= enable;
      end
   end
endmodule // trib_source

/* File: verif/group_to_path_adapter_tb.sv */
// self-checking bench for the tug-3 multiplex overhead source
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got %h want %h", $time, a, e); end end
module group_to_path_adapter_tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   reg pclk, presetn, psel, penable, pwrite, frame_start_in, multiframe_start;
   reg [7:0] paddr;
   reg [31:0] pwdata;
   wire [31:0] prdata;
   wire pready, pslverr, trib_valid, trib_ready, path_frame_start, path_clock_out, path_drive_enable;
   wire group_a_single_tu_flag, group_b_single_tu_flag;
   wire [7:0] trib_data, path_payload_data;
   reg feed_on; // partner may offer bytes
   reg [31:0] rng; // xorshift state
   reg [7:0] fcnt, opos; // input position, position of the output byte
   reg [1:0] mcnt, emfi; // frames since multiframe start, expected indicator
   reg sync; // columns known after the first frame start
   reg [7:0] ebyte; // next tributary byte due in a data slot
   integer n_fail, total_checks, i;
   reg [31:0] q;
   reg e;
   // activation sets, each filling the payload with one owner per slot
   localparam logic [31:0] ACT0 [4] = '{32'h001f_fffc, 32'h001f_0003, 32'h0, 32'h001f_0001};
   localparam logic [31:0] ACT1 [4] = '{32'h0, 32'h0, 32'hffff_ffff, 32'hffe0_0000};
   localparam logic [31:0] ACT2 [4] = '{32'h0, 32'h0, 32'h01ff_ffff, 32'h0000_03ff};
   localparam logic [1:0] FLG [4] = '{2'h0, 2'h3, 2'h0, 2'h1};
   group_to_path_adapter u_group_to_path_adapter (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .frame_start_in, .multiframe_start, .trib_data, .trib_valid, .trib_ready,
      .path_payload_data, .path_frame_start, .path_clock_out, .path_drive_enable, .group_a_single_tu_flag,
      .group_b_single_tu_flag);
   trib_source u_trib_source (.pclk, .presetn, .enable(feed_on & rng[0]), .trib_ready, .trib_data, .trib_valid);
   always #4 pclk = ~pclk;
   // ----------------------------------------------------------------
   // expectation helpers
   // ----------------------------------------------------------------
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // true where an output column carries tributary bytes
   function is_data(input [7:0] c, input fa, input fb);
      reg [7:0] g, w;
      begin
         g = (c - 8'h03) % 8'h03;
         w = (c - 8'h03) / 8'h03;
         is_data = c > 8'h02 && !(g == 8'h02 && w > 8'h04) && !(w == 8'h07 && ((g == 8'h00 && !fa) || (g == 8'h01 && !fb)));
      end
   endfunction
   // frame timing runs always, so the indicator never skips a frame
   always @(posedge pclk) begin
      rng <= xs(rng);
      fcnt <= (fcnt == 8'hf2) ? 8'h00 : fcnt + 8'h01;
      frame_start_in <= (fcnt == 8'hf2);
      multiframe_start <= (fcnt == 8'hf2) && (mcnt == 2'h3);
      mcnt <= (fcnt == 8'hf2) ? mcnt + 2'h1 : mcnt;
      opos <= fcnt;
      if (!presetn) begin
         emfi <= 2'h3;
         sync <= 1'b0;
         ebyte <= 8'h01;
      end else begin
         if (frame_start_in) begin
            emfi <= multiframe_start ? 2'h0 : emfi + 2'h1;
            sync <= 1'b1;
         end
         if (path_frame_start === 1'b1)
            `CHK(path_payload_data, {5'b00100, emfi, 1'b0})
         // the frame start reaches the outputs through the pass-through stage, only at byte 0
         if (sync && path_drive_enable === 1'b1)
            `CHK(path_frame_start, opos == 8'h00)
         // bytes leave in slot order; ff marks a starved slot
         if (sync && path_clock_out === 1'b1 && path_payload_data !== 8'hff
             && is_data(opos % 8'h1b, group_a_single_tu_flag, group_b_single_tu_flag)) begin
            `CHK(path_payload_data, ebyte)
            ebyte <= (path_payload_data == 8'hfe) ? 8'h01 : path_payload_data + 8'h01;
         end
      end
   end
   // one apb transfer; a read leaves data in q and the error flag in e
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge pclk);
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (k == 20) begin
            n_fail++;
            wrap_up;
         end
         @(posedge pclk);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {pclk, presetn, psel, penable, pwrite, frame_start_in, multiframe_start, feed_on} = 8'h00;
      {paddr, pwdata, fcnt, mcnt, n_fail, total_checks} = 0;
      rng = 32'h26;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // status shows indicator 3 and an empty fifo after reset
      for (i = 0; i < 6; i = i + 1) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         `CHK(q, (i == 4) ? 32'h30 : 32'h0)
      end
      apb(1'b0, 8'h18, 32'h0);
      `CHK({e, q}, 33'h1_0000_0000)
      $display("test reset_values done");
      // nothing is popped while inactive, so the fifo must fill and refuse
      feed_on <= 1'b1;
      for (i = 0; i < 100 && trib_ready !== 1'b0; i = i + 1)
         @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      `CHK({trib_ready, q[11:8], path_drive_enable}, 6'b0_1000_0)
      $display("test fifo_fill done");
      for (i = 0; i < 4; i = i + 1) begin
         apb(1'b1, 8'h04, ACT0[i]);
         apb(1'b1, 8'h08, ACT1[i]);
         apb(1'b1, 8'h0c, ACT2[i]);
         apb(1'b1, 8'h00, 32'h1);
         repeat (300) @(posedge pclk);
         // a frame start between the set writes may latch a mixed set; clear once the new set holds
         apb(1'b1, 8'h10, 32'h10);
         repeat (500) @(posedge pclk);
         `CHK({group_b_single_tu_flag, group_a_single_tu_flag}, FLG[i])
         apb(1'b0, 8'h10, 32'h0);
         `CHK({q[2:0], path_drive_enable}, {1'b0, FLG[i], 1'b1})
         $display("test config %0d done", i);
      end
      // drain with the feed stopped; starved slots then count underruns
      feed_on <= 1'b0;
      q = 32'hffff_ffff;
      for (i = 0; i < 60 && q[11:8] !== 4'h0; i = i + 1)
         apb(1'b0, 8'h10, 32'h0);
      `CHK(q[11:8], 4'h0)
      repeat (300) @(posedge pclk);
      apb(1'b0, 8'h14, 32'h0);
      `CHK(q[15:0] != 16'h0, 1'b1)
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      `CHK(q, 32'h0)
      repeat (300) @(posedge pclk);
      `CHK({path_drive_enable, path_clock_out}, 2'b00)
      $display("test drain_and_stop done");
      wrap_up;
   end
endmodule // group_to_path_adapter_tb
